// ==== shared/mfpc_pkg.sv ====
package mfpc_pkg;

    // APB geometry
    localparam int MFPC_ADDR_W = 12;
    localparam int MFPC_DATA_W = 32;
    localparam int MFPC_PINS = 3;

    // Register indices; byte address is four times the index
    localparam logic [7:0] MFPC_IDX_PIN3_CTRL = 8'h76;
    localparam logic [7:0] MFPC_IDX_PIN4_CTRL = 8'h77;
    localparam logic [7:0] MFPC_IDX_PIN5_CTRL = 8'h78;
    localparam logic [7:0] MFPC_IDX_IRQ_STATUS = 8'h79;
    localparam logic [7:0] MFPC_IDX_IRQ_MASK = 8'h7a;
    localparam logic [7:0] MFPC_IDX_PIN_LEVEL = 8'h7f;

    // Pin function codes
    localparam logic [5:0] MFPC_FN_SW_OUT = 6'h00;
    localparam logic [5:0] MFPC_FN_BCLK = 6'h01;
    localparam logic [5:0] MFPC_FN_IRQ = 6'h02;
    localparam logic [5:0] MFPC_FN_SW_IN = 6'h03;
    localparam logic [5:0] MFPC_FN_MIC_CUR = 6'h04;
    localparam logic [5:0] MFPC_FN_MIC_SHORT = 6'h05;

    // Pin control layout, bits 13:0 of the 16-bit control word
    typedef struct packed {
        logic [5:0] function_sel;
        logic direction;
        logic drive_type;
        logic input_polarity;
        logic out_level;
        logic pulldown_en;
        logic pullup_en;
        logic irq_trigger;
        logic debounce_en;
    } mfpc_pin_cfg_s;

    // Drive towards one pad
    typedef struct packed {
        logic out;
        logic oe;
        logic pullup_en;
        logic pulldown_en;
    } mfpc_pad_drive_s;

    localparam logic [13:0] MFPC_PIN3_RST = 14'h00a8;
    localparam logic [13:0] MFPC_PIN4_RST = 14'h0220;
    localparam logic [13:0] MFPC_PIN5_RST = 14'h01a8;

    // Interrupt flags sit at bits 4:2 of the status and mask words
    localparam int MFPC_IRQ_LSB = 2;
    localparam logic [2:0] MFPC_IRQ_MASK_RST = 3'h7;

    localparam int MFPC_DEBOUNCE_CYCLES = 16;

    function automatic logic [MFPC_ADDR_W-1:0] mfpc_byte_addr(logic [7:0] idx);
        return {2'h0, idx, 2'h0};
    endfunction

endpackage

// ==== design/mfpc_debounce.sv ====
`timescale 1ns/1ps
module mfpc_debounce #(
    parameter int CYCLES = mfpc_pkg::MFPC_DEBOUNCE_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Filter
    input wire logic raw,
    input wire logic enable,
    output logic filtered
);
    import mfpc_pkg::*;

    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] cnt_r;
    logic filt_r;

    assign filtered = filt_r;

    // A glitch shorter than the window restarts the count and never reaches the output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filt_r <= 1'b0;
            cnt_r <= '0;
        end else if (!enable) begin
            filt_r <= raw; // RULE12
            cnt_r <= '0;
        end else if (raw == filt_r) begin
            cnt_r <= '0;
        end else if (cnt_r == LAST) begin
            filt_r <= raw; // RULE14
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    chk_db_stable_window: assert property ( // RULE14
        @(posedge pclk) disable iff (!presetn)
        (enable && $past(enable) && $changed(filt_r)) |-> ($past(cnt_r) == LAST)
    ) else $error("debounced level changed before the window elapsed");

endmodule

// ==== design/mfpc_pin_ctrl.sv ====
`timescale 1ns/1ps
// What this block does
// RULE1 - Function code 00h software output, 02h interrupt out, 03h input, 05h short detect
// RULE2 - Function code 04h drives the mic bias current-detect indication out
// RULE3 - Third pin: function bits 13:8 reset to 00h, direction resets to input
// RULE4 - Fourth pin resets to interrupt output, direction bit 7 output
// RULE5 - Fifth pin only: code 01h is bit clock; resets to it, as input
// RULE6 - Bit 6 picks push-pull (0) or open-drain (1) driver; resets 0
// RULE7 - Bit 5 input polarity: 0 active low, 1 active high; resets 1
// RULE8 - Bit 4 driven level, used only in software output function; resets 0
// RULE9 - Bit 3 enables pull-down when 1
// RULE10 - Pull-down resets enabled on third and fifth pins, disabled on fourth
// RULE11 - Bit 2 enables pull-up when 1; resets 0 everywhere
// RULE12 - Bit 0 set debounces the input, clear passes it straight
// RULE13 - Bit 1 chooses level (0) or edge (1) interrupt; resets level
// RULE14 - Debounce needs the input stable several clocks before the output follows
// RULE15 - Each pin sets its own sticky status flag, third pin at bit 2
// RULE16 - Per-pin mask bit, reset masked, keeps the flag off the interrupt
module mfpc_pin_ctrl #(
    parameter int DEBOUNCE_CYCLES = mfpc_pkg::MFPC_DEBOUNCE_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [mfpc_pkg::MFPC_ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [mfpc_pkg::MFPC_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [mfpc_pkg::MFPC_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pads, index 0 is the third pin
    input wire logic [2:0] pin_in,
    output mfpc_pkg::mfpc_pad_drive_s [2:0] pad_drive,
    // Codec core
    input wire logic mic_current_det,
    input wire logic mic_short_det,
    input wire logic bit_clock_out,
    output logic bit_clock_from_pin,
    output logic irq_out
);
    import mfpc_pkg::*;

    mfpc_pin_cfg_s cfg_r [MFPC_PINS];
    mfpc_pad_drive_s [2:0] pad_r;
    logic [2:0] status_r;
    logic [2:0] mask_r;
    logic [2:0] active_prev_r;
    logic [MFPC_DATA_W-1:0] prdata_r;
    logic pslverr_r;
    logic bclk_in_r;
    logic [2:0] filt;
    logic [2:0] active;
    logic [2:0] evt;
    logic [2:0] hit_pin;
    logic hit_stat;
    logic hit_mask;
    logic hit_level;
    logic mapped;
    logic setup;
    logic access;
    logic wr;
    logic [15:0] rd_word;
    logic [2:0] clr;

    function automatic logic [15:0] merge16(logic [15:0] old, logic [31:0] wd, logic [3:0] st);
        return {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
    endfunction

    function automatic logic pin_value(mfpc_pin_cfg_s c, logic irq, logic det, logic shrt,
                                       logic bclk, logic is_pin5);
        logic v;
        v = 1'b0;
        case (c.function_sel)
            MFPC_FN_SW_OUT: v = c.out_level; // RULE8
            MFPC_FN_IRQ: v = irq; // RULE1
            MFPC_FN_MIC_CUR: v = det; // RULE2
            MFPC_FN_MIC_SHORT: v = shrt; // RULE1
            MFPC_FN_BCLK: v = is_pin5 & bclk; // RULE5
            default: v = 1'b0;
        endcase
        return v;
    endfunction

    function automatic logic pin_drives(mfpc_pin_cfg_s c, logic is_pin5);
        logic d;
        d = 1'b0;
        case (c.function_sel)
            MFPC_FN_SW_OUT, MFPC_FN_IRQ, MFPC_FN_MIC_CUR, MFPC_FN_MIC_SHORT: d = 1'b1;
            MFPC_FN_BCLK: d = is_pin5;
            default: d = 1'b0;
        endcase
        return d & ~c.direction;
    endfunction

    // Address decode
    always_comb begin
        hit_pin = 3'h0;
        hit_stat = 1'b0;
        hit_mask = 1'b0;
        hit_level = 1'b0;
        if (paddr == mfpc_byte_addr(MFPC_IDX_PIN3_CTRL)) begin
            hit_pin[0] = 1'b1;
        end else if (paddr == mfpc_byte_addr(MFPC_IDX_PIN4_CTRL)) begin
            hit_pin[1] = 1'b1;
        end else if (paddr == mfpc_byte_addr(MFPC_IDX_PIN5_CTRL)) begin
            hit_pin[2] = 1'b1;
        end else if (paddr == mfpc_byte_addr(MFPC_IDX_IRQ_STATUS)) begin
            hit_stat = 1'b1;
        end else if (paddr == mfpc_byte_addr(MFPC_IDX_IRQ_MASK)) begin
            hit_mask = 1'b1;
        end else if (paddr == mfpc_byte_addr(MFPC_IDX_PIN_LEVEL)) begin
            hit_level = 1'b1;
        end
    end

    assign mapped = (|hit_pin) | hit_stat | hit_mask | hit_level;
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign wr = access & pwrite & mapped;
    assign pready = access;
    assign pslverr = access & pslverr_r;
    assign prdata = prdata_r;

    always_comb begin
        rd_word = 16'h0000;
        if (hit_pin[0]) begin
            rd_word = {2'h0, cfg_r[0]};
        end else if (hit_pin[1]) begin
            rd_word = {2'h0, cfg_r[1]};
        end else if (hit_pin[2]) begin
            rd_word = {2'h0, cfg_r[2]};
        end else if (hit_stat) begin
            rd_word = 16'(status_r) << MFPC_IRQ_LSB;
        end else if (hit_mask) begin
            rd_word = 16'(mask_r) << MFPC_IRQ_LSB;
        end else if (hit_level) begin
            rd_word = 16'(active) << MFPC_IRQ_LSB;
        end
    end

    // Read data is captured in the setup phase so the access phase needs no wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= '0;
            pslverr_r <= 1'b0;
        end else if (setup) begin
            prdata_r <= pwrite ? '0 : {16'h0000, rd_word};
            pslverr_r <= ~mapped;
        end
    end

    // Pin control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r[0] <= MFPC_PIN3_RST; // RULE3
            cfg_r[1] <= MFPC_PIN4_RST; // RULE4
            cfg_r[2] <= MFPC_PIN5_RST; // RULE5
        end else if (wr) begin
            for (int i = 0; i < MFPC_PINS; i++) begin
                if (hit_pin[i]) begin
                    cfg_r[i] <= 14'(merge16({2'h0, cfg_r[i]}, pwdata, pstrb));
                end
            end
        end
    end

    // Input conditioning
    for (genvar g = 0; g < MFPC_PINS; g++) begin : g_in
        mfpc_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_db (
            .pclk(pclk),
            .presetn(presetn),
            .raw(pin_in[g]),
            .enable(cfg_r[g].debounce_en),
            .filtered(filt[g])
        );
        assign active[g] = cfg_r[g].input_polarity ? filt[g] : ~filt[g]; // RULE7
        assign evt[g] = (cfg_r[g].function_sel == MFPC_FN_SW_IN)
                        & active[g] & (~cfg_r[g].irq_trigger | ~active_prev_r[g]); // RULE13
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_prev_r <= 3'h0;
        end else begin
            active_prev_r <= active;
        end
    end

    // Interrupt flags; a new event in the clearing cycle keeps its flag
    assign clr = (wr & hit_stat & pstrb[0]) ? pwdata[MFPC_IRQ_LSB +: 3] : 3'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_r <= 3'h0;
        end else begin
            status_r <= (status_r & ~clr) | evt; // RULE15
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= MFPC_IRQ_MASK_RST; // RULE16
        end else if (wr & hit_mask & pstrb[0]) begin
            mask_r <= pwdata[MFPC_IRQ_LSB +: 3];
        end
    end

    assign irq_out = |(status_r & ~mask_r); // RULE16

    // Pad drive; open-drain only ever pulls low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_r[0] <= 4'b0001; // RULE10
            pad_r[1] <= 4'b0000;
            pad_r[2] <= 4'b0001; // RULE10
        end else begin
            for (int i = 0; i < MFPC_PINS; i++) begin
                logic v;
                logic d;
                v = pin_value(cfg_r[i], irq_out, mic_current_det, mic_short_det,
                              bit_clock_out, i == 2);
                d = pin_drives(cfg_r[i], i == 2);
                if (cfg_r[i].drive_type) begin
                    pad_r[i].out <= 1'b0; // RULE6
                    pad_r[i].oe <= d & ~v;
                end else begin
                    pad_r[i].out <= d & v;
                    pad_r[i].oe <= d;
                end
                pad_r[i].pullup_en <= cfg_r[i].pullup_en; // RULE11
                pad_r[i].pulldown_en <= cfg_r[i].pulldown_en; // RULE9
            end
        end
    end

    assign pad_drive = pad_r;

    // Bit clock arriving on the fifth pin while it is an input
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bclk_in_r <= 1'b0;
        end else begin
            bclk_in_r <= (cfg_r[2].function_sel == MFPC_FN_BCLK)
                         & cfg_r[2].direction & pin_in[2]; // RULE5
        end
    end

    assign bit_clock_from_pin = bclk_in_r;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_sw_out_level: assert property ( // RULE8
        (cfg_r[0].function_sel == MFPC_FN_SW_OUT && !cfg_r[0].direction
         && !cfg_r[0].drive_type) |=> (pad_drive[0].oe && pad_drive[0].out == $past(cfg_r[0].out_level))
    ) else $error("software output level not driven on third pin");

    chk_irq_pin_route: assert property ( // RULE1
        (cfg_r[1].function_sel == MFPC_FN_IRQ && !cfg_r[1].direction && !cfg_r[1].drive_type)
        |=> (pad_drive[1].out == $past(irq_out))
    ) else $error("interrupt not routed to fourth pin");

    chk_micdet_route: assert property ( // RULE2
        (cfg_r[0].function_sel == MFPC_FN_MIC_CUR && !cfg_r[0].direction && !cfg_r[0].drive_type)
        |=> (pad_drive[0].out == $past(mic_current_det))
    ) else $error("current detect not routed");

    chk_short_route: assert property ( // RULE1
        (cfg_r[2].function_sel == MFPC_FN_MIC_SHORT && !cfg_r[2].direction && !cfg_r[2].drive_type)
        |=> (pad_drive[2].out == $past(mic_short_det))
    ) else $error("short detect not routed");

    chk_bclk_route: assert property ( // RULE5
        (cfg_r[2].function_sel == MFPC_FN_BCLK && !cfg_r[2].direction && !cfg_r[2].drive_type)
        |=> (pad_drive[2].oe && pad_drive[2].out == $past(bit_clock_out))
    ) else $error("bit clock not driven on fifth pin");

    chk_open_drain_low: assert property ( // RULE6
        $past(cfg_r[0].drive_type) |-> !(pad_drive[0].oe && pad_drive[0].out)
    ) else $error("open-drain pin drove high");

    chk_input_no_drive: assert property ( // RULE1
        (cfg_r[0].function_sel == MFPC_FN_SW_IN) |=> !pad_drive[0].oe
    ) else $error("input pin is driving");

    chk_low_polarity: assert property ( // RULE7
        (!cfg_r[0].input_polarity && !cfg_r[0].debounce_en && !pin_in[0])
        |=> (!cfg_r[0].input_polarity |-> active[0])
    ) else $error("active-low input not seen as active");

    chk_flag_sets: assert property ( // RULE15
        evt[0] |=> status_r[0]
    ) else $error("third pin flag did not set");

    chk_edge_once: assert property ( // RULE13
        (cfg_r[0].irq_trigger && active_prev_r[0]) |-> !evt[0]
    ) else $error("edge mode fired on a held level");

    chk_mask_blocks: assert property ( // RULE16
        (mask_r == 3'h7) |-> !irq_out
    ) else $error("masked flag raised the interrupt");

endmodule

// ==== bench/mfpc_pad_model.sv ====
`timescale 1ns/1ps
module mfpc_pad_model (
    // Clock
    input wire logic pclk,
    // Pad side of the block
    input wire mfpc_pkg::mfpc_pad_drive_s [2:0] pad_drive,
    output logic [2:0] pin_in,
    // Board drivers
    input wire logic [2:0] ext_val,
    input wire logic [2:0] ext_en
);
    import mfpc_pkg::*;
    logic [2:0] last_r;
    always_ff @(posedge pclk) begin
        last_r <= pin_in;
    end
    // A pin nobody drives or pulls toggles, so a stale value never passes
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            if (pad_drive[i].oe) begin
                pin_in[i] = pad_drive[i].out;
            end else if (ext_en[i]) begin
                pin_in[i] = ext_val[i];
            end else if (pad_drive[i].pullup_en) begin
                pin_in[i] = 1'b1;
            end else if (pad_drive[i].pulldown_en) begin
                pin_in[i] = 1'b0;
            end else begin
                pin_in[i] = last_r[i] ? 1'b0 : 1'b1;
            end
        end
    end
endmodule

// ==== bench/multi_function_pin_control_test.sv ====
`timescale 1ns/1ps
module multi_function_pin_control_test;
    import mfpc_pkg::*;
    localparam int DB = 4;
    localparam logic [11:0] A3 = {2'h0, MFPC_IDX_PIN3_CTRL, 2'h0};
    localparam logic [11:0] A4 = {2'h0, MFPC_IDX_PIN4_CTRL, 2'h0};
    localparam logic [11:0] A5 = {2'h0, MFPC_IDX_PIN5_CTRL, 2'h0};
    localparam logic [11:0] AS = {2'h0, MFPC_IDX_IRQ_STATUS, 2'h0};
    localparam logic [11:0] AM = {2'h0, MFPC_IDX_IRQ_MASK, 2'h0};
    localparam logic [11:0] AL = {2'h0, MFPC_IDX_PIN_LEVEL, 2'h0};
    // Detector levels, expected pad drive, control word
    localparam logic [21:0] TBL [7] = '{22'h0c0010, 22'h000050, 22'h060044,
        22'h2d0418, 22'h240510, 22'h1c0500, 22'h300610};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] pin_in;
    logic [2:0] ext_val = 3'h0;
    logic [2:0] ext_en = 3'h0;
    mfpc_pad_drive_s [2:0] pad_drive;
    logic mic_cur = 1'b0;
    logic mic_short = 1'b0;
    logic bclk_out = 1'b0;
    logic bclk_pin;
    logic irq_out;
    logic [31:0] rd;
    logic rerr;
    int err_count = 0;
    int checks = 0;

    always #25 pclk = ~pclk;

    mfpc_pin_ctrl #(.DEBOUNCE_CYCLES(DB)) i_dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .pad_drive(pad_drive),
        .mic_current_det(mic_cur), .mic_short_det(mic_short), .bit_clock_out(bclk_out),
        .bit_clock_from_pin(bclk_pin), .irq_out(irq_out)
    );
    mfpc_pad_model i_pads (
        .pclk(pclk), .pad_drive(pad_drive), .pin_in(pin_in), .ext_val(ext_val), .ext_en(ext_en)
    );

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            chk("pready", pready, 32'h1);
        end
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    task automatic drv(input logic [2:0] en, input logic [2:0] v);
        @(posedge pclk);
        ext_en <= en;
        ext_val <= v;
    endtask

    task automatic finish_test;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        wait_n(2);
        chk("pad3", pad_drive[0], 32'h1);
        chk("pad4", pad_drive[1], 32'h4);
        chk("pad5", pad_drive[2], 32'h1);
        rdchk("ctl3", A3, 32'h00a8);
        rdchk("ctl4", A4, 32'h0220);
        rdchk("ctl5", A5, 32'h01a8);
        rdchk("mask", AM, 32'h1c);
        rdchk("stat", AS, 32'h0);
        apb(1'b0, 12'h100, 32'h0);
        chk("slverr", rerr, 32'h1);
        drv(3'h4, 3'h4);
        wait_n(3);
        chk("bclk", bclk_pin, 32'h1);
        drv(3'h4, 3'h0);
        wait_n(3);
        chk("bclk", bclk_pin, 32'h0);
        drv(3'h0, 3'h0);
        for (int i = 0; i < 7; i++) begin
            @(posedge pclk);
            {mic_cur, mic_short} <= TBL[i][21:20];
            apb(1'b1, A3, {16'h0, TBL[i][15:0]});
            wait_n(3);
            chk("pad3_fn", pad_drive[0], {28'h0, TBL[i][19:16]});
        end
        // Input path, level trigger, active high, no filter
        drv(3'h1, 3'h0);
        apb(1'b1, A3, 32'h03a0);
        wait_n(3);
        apb(1'b1, AS, 32'h1c);
        drv(3'h1, 3'h1);
        wait_n(3);
        rdchk("stat", AS, 32'h4);
        chk("irq_masked", irq_out, 32'h0);
        apb(1'b1, AM, 32'h18);
        wait_n(2);
        chk("irq", irq_out, 32'h1);
        chk("pad4_irq", pad_drive[1], 32'hc);
        apb(1'b1, AS, 32'h4);
        rdchk("stat_lvl", AS, 32'h4);
        apb(1'b1, A3, 32'h03a2);
        apb(1'b1, AS, 32'h4);
        rdchk("stat_edge", AS, 32'h0);
        drv(3'h1, 3'h0);
        wait_n(3);
        drv(3'h1, 3'h1);
        wait_n(3);
        rdchk("stat_edge", AS, 32'h4);
        // Active low: a high pin is idle
        apb(1'b1, A3, 32'h0380);
        apb(1'b1, AS, 32'h4);
        rdchk("stat_pol", AS, 32'h0);
        drv(3'h1, 3'h0);
        wait_n(3);
        rdchk("stat_pol", AS, 32'h4);
        // Third pin active low and driven low, fourth pin carries the raised interrupt
        rdchk("level", AL, 32'hc);
        // Short pulses must not pass the filter
        apb(1'b1, A3, 32'h03a1);
        wait_n(DB + 4);
        apb(1'b1, AS, 32'h4);
        drv(3'h1, 3'h1);
        drv(3'h1, 3'h0);
        wait_n(DB + 4);
        rdchk("stat_db", AS, 32'h0);
        drv(3'h1, 3'h1);
        wait_n(DB + 4);
        rdchk("stat_db", AS, 32'h4);
        // Fifth pin as bit clock output, then as short detect output
        apb(1'b1, A5, 32'h0120);
        @(posedge pclk);
        bclk_out <= 1'b1;
        wait_n(2);
        chk("pad5_bclk", pad_drive[2], 32'hc);
        chk("bclk_in", bclk_pin, 32'h0);
        @(posedge pclk);
        bclk_out <= 1'b0;
        wait_n(2);
        chk("pad5_bclk", pad_drive[2], 32'h4);
        apb(1'b1, A5, 32'h0520);
        wait_n(2);
        chk("pad5_short", pad_drive[2], 32'hc);
        finish_test;
    end

    initial begin
        #(50 * 5000);
        err_count++;
        finish_test;
    end
endmodule
